/* File: rtl/die_temp_and_thermistor_alarm.sv */
// Summary of operation
// R1: Die result sign bit: 1 negative, 0 positive.
// R2: Die temperature is 5C plus code times 0.5C.
// R3: Die result bytes read-only, cleared by register reset.
// R4: Alarm when bus reading within 5 percent.
// R5: Alarm when battery reading within 5 percent.
// R6: Bus threshold counts 0.19531 percent each.
// R7: Battery threshold counts 0.19531 percent each.
// R8: Both thresholds reset to 15h.
// R9: Readings are pin voltage percent of output voltage.
// R10: Thresholds read/write, kept on watchdog expiry.
`timescale 1ns/10ps
`default_nettype none
module die_temp_and_thermistor_alarm (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port, decoded from the serial interface on this clock.
  input wire thermistor_pkg::reg_access_t i_access,
  input wire logic i_register_reset,
  input wire logic i_watchdog_expired,
  output logic [7:0] o_rdata,
  // Converter results on this clock.
  input wire logic i_result_valid,
  input wire thermistor_pkg::reading_t i_die_temp_result,
  input wire thermistor_pkg::reading_t i_bus_thermistor_pin,
  input wire thermistor_pkg::reading_t i_battery_thermistor_pin,
  // Alarm.
  output logic o_thermistor_alarm_interrupt
);
  thermistor_pkg::reading_t die_q;
  logic [7:0] bus_thr_q;
  logic [7:0] bat_thr_q;
  logic bus_near;
  logic bat_near;
  logic clear_all;

  assign clear_all = i_srst | i_register_reset;

  // One address decoder serves the write path and the threshold and die low byte readback checks, so they cannot disagree.
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addr_is

  // The converter already reports the code as offset plus half-degree steps. R2
  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      die_q <= {thermistor_pkg::die_result_reset, thermistor_pkg::die_result_reset}; // R3
    end else if (i_result_valid) begin
      die_q <= i_die_temp_result; // R1
    end
  end

  // Watchdog expiry is deliberately ignored here so thresholds survive it.
  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      bus_thr_q <= thermistor_pkg::threshold_reset; // R8
      bat_thr_q <= thermistor_pkg::threshold_reset; // R8
    end else if (i_access.write) begin
      if (addr_is(i_access.addr, thermistor_pkg::addr_bus_flt)) begin
        bus_thr_q <= i_access.wdata; // R10
      end
      if (addr_is(i_access.addr, thermistor_pkg::addr_bat_flt)) begin
        bat_thr_q <= i_access.wdata; // R10
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      o_rdata <= 8'h00;
    end else if (i_access.read) begin
      case (i_access.addr)
        thermistor_pkg::addr_die_high: o_rdata <= {die_q.sign, die_q.magnitude[14:8]}; // R1
        thermistor_pkg::addr_die_low: o_rdata <= die_q.magnitude[7:0];
        thermistor_pkg::addr_bus_flt: o_rdata <= bus_thr_q; // R10
        thermistor_pkg::addr_bat_flt: o_rdata <= bat_thr_q;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Both comparators work on the shared pin-to-output-voltage percent scale. R9
  band_compare u_bus_cmp (
    .i_reading(i_bus_thermistor_pin.magnitude),
    .i_negative(i_bus_thermistor_pin.sign),
    .i_threshold(bus_thr_q), // R6
    .o_near(bus_near)
  );

  band_compare u_bat_cmp (
    .i_reading(i_battery_thermistor_pin.magnitude),
    .i_negative(i_battery_thermistor_pin.sign),
    .i_threshold(bat_thr_q), // R7
    .o_near(bat_near)
  );

  // Evaluated only on fresh results so stale readings cannot hold the alarm.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_thermistor_alarm_interrupt <= 1'b0;
    end else if (i_result_valid) begin
      o_thermistor_alarm_interrupt <= bus_near | bat_near; // R4 R5
    end
  end

  a_die_clear: assert property (@(posedge i_clock) disable iff (i_srst)
    i_register_reset |=> (die_q == 16'h0000)) // R3
    else $error("die result not cleared by register reset");

  a_thr_reset: assert property (@(posedge i_clock)
    clear_all |=> (bus_thr_q == 8'h15 && bat_thr_q == 8'h15)) // R8
    else $error("threshold reset value wrong");

  a_thr_keep: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_watchdog_expired && !clear_all && !i_access.write) |=> $stable(bus_thr_q)) // R10
    else $error("threshold changed on watchdog");

  a_bus_write: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_access.write && i_access.addr == 8'h28 && !i_register_reset)
    |=> bus_thr_q == $past(i_access.wdata)) // R6
    else $error("bus threshold write lost");

  a_bat_write: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_access.write && i_access.addr == 8'h29 && !i_register_reset)
    |=> bat_thr_q == $past(i_access.wdata)) // R7
    else $error("battery threshold write lost");

  a_sign_read: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_access.read && i_access.addr == 8'h26 && !i_register_reset)
    |=> o_rdata[7] == $past(die_q.sign)) // R1
    else $error("die sign bit misplaced");

  a_bus_alarm: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_result_valid && !i_bus_thermistor_pin.sign
     && i_bus_thermistor_pin.magnitude == {6'h00, bus_thr_q, 1'b0})
    |=> o_thermistor_alarm_interrupt) // R4
    else $error("bus alarm missed at threshold");

  a_bat_alarm: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_result_valid && !i_battery_thermistor_pin.sign
     && i_battery_thermistor_pin.magnitude == {6'h00, bat_thr_q, 1'b0})
    |=> o_thermistor_alarm_interrupt) // R5
    else $error("battery alarm missed at threshold");

  a_no_alarm: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_result_valid && !bus_near && !bat_near) |=> !o_thermistor_alarm_interrupt) // R4
    else $error("spurious alarm");

  // Band checks are worked out here independently of the comparator module.
  sequence s_bus_far;
    !i_bus_thermistor_pin.sign
    && ({1'b0, i_bus_thermistor_pin.magnitude}
        > ({7'h00, bus_thr_q, 1'b0} + {1'b0, thermistor_pkg::alarm_band}));
  endsequence

  sequence s_bat_far;
    !i_battery_thermistor_pin.sign
    && ({1'b0, i_battery_thermistor_pin.magnitude}
        > ({7'h00, bat_thr_q, 1'b0} + {1'b0, thermistor_pkg::alarm_band}));
  endsequence

  sequence s_bus_upper_edge;
    !i_bus_thermistor_pin.sign
    && ({1'b0, i_bus_thermistor_pin.magnitude}
        == ({7'h00, bus_thr_q, 1'b0} + {1'b0, thermistor_pkg::alarm_band}));
  endsequence

  sequence s_bat_lower_edge;
    !i_battery_thermistor_pin.sign
    && (({1'b0, i_battery_thermistor_pin.magnitude} + {1'b0, thermistor_pkg::alarm_band})
        == {7'h00, bat_thr_q, 1'b0});
  endsequence

  sequence s_read_bus;
    i_access.read && addr_is(i_access.addr, thermistor_pkg::addr_bus_flt) && !clear_all;
  endsequence

  sequence s_read_bat;
    i_access.read && addr_is(i_access.addr, thermistor_pkg::addr_bat_flt) && !clear_all;
  endsequence

  a_far_quiet: assert property (@(posedge i_clock) disable iff (i_srst) // R4 R5
    (i_result_valid ##0 s_bus_far ##0 s_bat_far) |=> !o_thermistor_alarm_interrupt)
    else $error("alarm raised outside both bands");

  a_bus_band_edge: assert property (@(posedge i_clock) disable iff (i_srst) // R4
    (i_result_valid ##0 s_bus_upper_edge) |=> o_thermistor_alarm_interrupt)
    else $error("bus alarm missed at band edge");

  a_bat_band_edge: assert property (@(posedge i_clock) disable iff (i_srst) // R5
    (i_result_valid ##0 s_bat_lower_edge) |=> o_thermistor_alarm_interrupt)
    else $error("battery alarm missed at band edge");

  a_alarm_hold: assert property (@(posedge i_clock) disable iff (i_srst) // R4
    !i_result_valid |=> $stable(o_thermistor_alarm_interrupt))
    else $error("alarm changed without new results");

  a_alarm_reset: assert property (@(posedge i_clock) // R4
    i_srst |=> !o_thermistor_alarm_interrupt)
    else $error("alarm not cleared by reset");

  a_bus_readback: assert property (@(posedge i_clock) disable iff (i_srst) // R10
    s_read_bus |=> o_rdata == $past(bus_thr_q))
    else $error("bus threshold readback wrong");

  a_bat_readback: assert property (@(posedge i_clock) disable iff (i_srst) // R10
    s_read_bat |=> o_rdata == $past(bat_thr_q))
    else $error("battery threshold readback wrong");

  a_low_read: assert property (@(posedge i_clock) disable iff (i_srst) // R3
    (i_access.read && addr_is(i_access.addr, thermistor_pkg::addr_die_low) && !clear_all)
    |=> o_rdata == $past(die_q.magnitude[7:0]))
    else $error("die low byte readback wrong");

  a_rdata_hold: assert property (@(posedge i_clock) disable iff (i_srst) // R10
    (!i_access.read && !clear_all) |=> $stable(o_rdata))
    else $error("read data changed without a read");

  a_rdata_clear: assert property (@(posedge i_clock) // R3
    clear_all |=> o_rdata == 8'h00)
    else $error("read data not cleared");

  a_die_ro: assert property (@(posedge i_clock) disable iff (i_srst) // R3
    (i_access.write && !i_result_valid && !clear_all) |=> $stable(die_q))
    else $error("die result written by software");

  a_die_load: assert property (@(posedge i_clock) disable iff (i_srst) // R2
    (i_result_valid && !clear_all) |=> die_q == $past(i_die_temp_result))
    else $error("die result not captured");

  // Unmapped reads return zero so software never sees stale bytes from a neighbour.
  a_unmapped_read: assert property (@(posedge i_clock) disable iff (i_srst) // R3
    (i_access.read && !clear_all && (i_access.addr < thermistor_pkg::addr_die_high
     || i_access.addr > thermistor_pkg::addr_bat_flt)) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

endmodule : die_temp_and_thermistor_alarm
`default_nettype wire

/* File: rtl/thermistor_pkg.sv */
package thermistor_pkg;

  localparam logic [7:0] addr_die_high = 8'h26;
  localparam logic [7:0] addr_die_low = 8'h27;
  localparam logic [7:0] addr_bus_flt = 8'h28;
  localparam logic [7:0] addr_bat_flt = 8'h29;

  localparam logic [7:0] threshold_reset = 8'h15;
  localparam logic [7:0] die_result_reset = 8'h00;
  localparam int die_sign_bit = 7;

  // Readings are 15-bit magnitudes in 0.09766 percent counts; thresholds are 0.19531
  // percent counts, so a threshold is shifted left by one onto the reading scale.
  localparam int threshold_shift = 1;
  // Five percent in reading counts: 5 / 0.09766 = 51.2, rounded down.
  localparam logic [14:0] alarm_band = 15'h0033;

  typedef struct packed {
    logic sign;
    logic [14:0] magnitude;
  } reading_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

endpackage : thermistor_pkg

/* File: rtl/band_compare.sv */
`timescale 1ns/10ps
`default_nettype none
module band_compare (
  // Reading on the reading scale; threshold in threshold counts, scaled here.
  input wire logic [14:0] i_reading,
  input wire logic i_negative,
  input wire logic [7:0] i_threshold,
  // Result.
  output logic o_near
);
  logic [15:0] thr_scaled;
  logic [15:0] diff;

  always_comb begin
    thr_scaled = {7'h00, i_threshold, 1'b0};
    if ({1'b0, i_reading} >= thr_scaled) begin
      diff = {1'b0, i_reading} - thr_scaled;
    end else begin
      diff = thr_scaled - {1'b0, i_reading};
    end
    // A negative reading is below any threshold by its magnitude plus the threshold.
    if (i_negative) begin
      diff = thr_scaled + {1'b0, i_reading};
    end
    o_near = (diff <= {1'b0, thermistor_pkg::alarm_band});
  end
endmodule : band_compare
`default_nettype wire

/* File: sim/therm_source.sv */
`timescale 1ns/10ps
`default_nettype none
module therm_source (
  // Clock, reset and request.
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_start,
  input wire thermistor_pkg::reading_t i_bus,
  input wire thermistor_pkg::reading_t i_bat,
  // Pin readings towards the block.
  output logic o_valid,
  output thermistor_pkg::reading_t o_bus,
  output thermistor_pkg::reading_t o_bat
);
  // Readings are pin voltage as a percentage of the output voltage.
  // Outside a result the lines flip, so stale values are never read as valid.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_valid <= 1'b0;
      o_bus <= '0;
      o_bat <= '0;
    end else begin
      o_valid <= i_start;
      o_bus <= i_start ? i_bus : ~o_bus;
      o_bat <= i_start ? i_bat : ~o_bat;
    end
  end
endmodule : therm_source
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_top;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  thermistor_pkg::reg_access_t i_access = '0;
  logic rrst = 1'b0;
  logic wdog = 1'b0;
  logic start = 1'b0;
  logic valid;
  logic alarm;
  logic [7:0] o_rdata;
  thermistor_pkg::reading_t die = '0;
  thermistor_pkg::reading_t bus_in = '0;
  thermistor_pkg::reading_t bat_in = '0;
  thermistor_pkg::reading_t bus_pin;
  thermistor_pkg::reading_t bat_pin;
  int num_errors = 0;
  int compares = 0;
  always #4 i_clock = ~i_clock;
  therm_source u_src (.i_clock(i_clock), .i_srst(i_srst), .i_start(start), .i_bus(bus_in),
    .i_bat(bat_in), .o_valid(valid), .o_bus(bus_pin), .o_bat(bat_pin));
  die_temp_and_thermistor_alarm u_dut (.i_clock(i_clock), .i_srst(i_srst),
    .i_access(i_access), .i_register_reset(rrst), .i_watchdog_expired(wdog),
    .o_rdata(o_rdata), .i_result_valid(valid), .i_die_temp_result(die),
    .i_bus_thermistor_pin(bus_pin), .i_battery_thermistor_pin(bat_pin),
    .o_thermistor_alarm_interrupt(alarm));
  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Two cycles per access, so no strobe is written twice in one time step.
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_access = '{w, ~w, a, w ? d : 8'h00};
    @(posedge i_clock);
    #1;
    i_access = '0;
    @(posedge i_clock);
    #1;
    if (!w) `CHK(o_rdata, d)
  endtask : acc
  task alm(input logic [14:0] b, input logic [14:0] t, input logic e);
    bus_in = '{1'b0, b};
    bat_in = '{1'b0, t};
    start = 1'b1;
    @(posedge i_clock);
    #1;
    start = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    `CHK(alarm, e)
  endtask : alm
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    acc(0, 8'h28, 8'h15);
    acc(0, 8'h29, 8'h15);
    acc(0, 8'h26, 8'h00);
    acc(0, 8'h2a, 8'h00);
    acc(1, 8'h28, 8'h40);
    acc(1, 8'h29, 8'h41);
    acc(1, 8'h26, 8'hff);
    acc(0, 8'h26, 8'h00);
    wdog = 1'b1;
    @(posedge i_clock);
    #1;
    wdog = 1'b0;
    acc(0, 8'h28, 8'h40);
    acc(0, 8'h29, 8'h41);
    die = '{1'b1, 15'h0123};
    alm(15'h0080, 15'h7fff, 1'b1);
    alm(15'h7fff, 15'h0082, 1'b1);
    alm(15'h00b3, 15'h7fff, 1'b1);
    alm(15'h00b4, 15'h7fff, 1'b0);
    alm(15'h7fff, 15'h004f, 1'b1);
    alm(15'h7fff, 15'h004e, 1'b0);
    acc(0, 8'h26, 8'h81);
    acc(0, 8'h27, 8'h23);
    rrst = 1'b1;
    @(posedge i_clock);
    #1;
    rrst = 1'b0;
    acc(0, 8'h29, 8'h15);
    acc(0, 8'h27, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
